/* src/sensor_fault_output_encoder.sv */
// fault signalling on one die's output pin, analog or pwm variant, apb registers
//
// The implementer's own choices: the APB register port and the address map.
`include "fault_enc_map.svh"

// What this block does
// - enabled diagnostics force error output at once
// - setup bit 7 picks upper/lower band
// - overtemperature puts output driver in hi-z
// - supply wire break drives output low
// - overvoltage check, eeprom self-test at power-up
// - continuous rom parity, fsm, adder checks
// - pwm error mode runs at half frequency
// - duty 95/85/75 for selftest/adder/overvoltage
// - undervoltage coded as 100 percent duty
// - setup bit 1 set leaves output unforced by diagnostics
// - unlocked analog part always uses high band
// - latch bit 2 holds flags until reset
module sensor_fault_output_encoder
    import fault_enc_pkg::*;
#(
    parameter int PW = 16
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        undervoltage,
    input  wire logic                        overvoltage,
    input  wire logic                        overtemperature,
    input  wire logic                        supply_break,
    input  wire logic                        ee_test_done,
    input  wire logic                        ee_test_pass,
    input  wire logic                        rom_parity_err,
    input  wire logic                        fsm_check_err,
    input  wire logic                        adder_overflow,
    output logic                             ee_test_start,
    output logic                             die_output_pin_o,
    output logic                             die_output_pin_oe,
    output fault_enc_pkg::analog_mode_t      analog_mode
);
    import fault_enc_pkg::*;

    // one extra counter bit holds the doubled error period
    localparam int CW = PW + 1;

    if (PW < 8 || PW > 24) begin : g_chk
        $error("PW must lie between 8 and 24");
    end

    // registers and state
    logic [15:0]   setup_q;
    logic [1:0]    ctrl_q;
    logic [PW-1:0] period_q;
    logic [PW-1:0] duty_q;
    logic [7:0]    flags_q;
    logic [7:0]    flags_d;
    logic          ee_fail_q;
    logic          ee_started_q;
    enc_state_t    state_q;
    enc_state_t    state_d;

    // synchronised pin levels
    logic [7:0] raw_async;
    logic [7:0] raw;

    // every fault pin is a level from another domain; the eeprom pass level goes through
    // the flops raw, since gating it with done first could glitch a false fail
    assign raw_async = {supply_break, overtemperature, overvoltage, adder_overflow,
                        rom_parity_err, fsm_check_err, ee_test_pass,
                        undervoltage};

    fault_sync #(.W(8)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (raw_async),
        .sync_out (raw)
    );

    logic ee_done_s;
    fault_sync #(.W(1)) u_sync_done (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (ee_test_done),
        .sync_out (ee_done_s)
    );

    // a fail only counts once the test reports done
    wire ee_failed = ee_done_s & ~raw[`FE_F_EE];

    // diagnostic evaluation
    wire diag_en   = ctrl_q[`FE_CTRL_DIAG_EN];
    wire pwm_var   = ctrl_q[`FE_CTRL_PWM];
    wire ov_active = ~setup_q[`FE_SETUP_OV_OFF];
    wire latch_on  = setup_q[`FE_SETUP_LATCH];
    wire locked    = setup_q[`FE_SETUP_LOCK];
    // a state register that is not one-hot is itself a state machine fault
    wire own_fsm_bad = ~$onehot(state_q);

    // undervoltage, overtemperature and wire break are always watched; the rest wait for diag enable
    logic [7:0] live;
    assign live[`FE_F_UV]  = raw[`FE_F_UV];
    assign live[`FE_F_EE]  = diag_en & ee_fail_q;
    assign live[`FE_F_FSM] = diag_en & (raw[`FE_F_FSM] | own_fsm_bad);
    assign live[`FE_F_ROM] = diag_en & raw[`FE_F_ROM];
    assign live[`FE_F_ADD] = diag_en & raw[`FE_F_ADD];
    assign live[`FE_F_OV]  = diag_en & ov_active & raw[`FE_F_OV];
    assign live[`FE_F_OT]  = raw[`FE_F_OT];
    assign live[`FE_F_BRK] = raw[`FE_F_BRK];

    // a latched flag stays set until power-on reset; set always beats any release
    assign flags_d = latch_on ? (flags_q | live) : live;

    wire selftest_f = flags_q[`FE_F_EE] | flags_q[`FE_F_FSM] | flags_q[`FE_F_ROM];
    wire any_diag   = flags_q[`FE_F_UV] | selftest_f | flags_q[`FE_F_ADD] | flags_q[`FE_F_OV];
    wire force_err  = ~setup_q[`FE_SETUP_DIAG_OFF] & any_diag;

    // wire break outranks overtemperature, which outranks diagnostics
    always_comb begin
        if (flags_q[`FE_F_BRK]) begin
            state_d = ST_GROUND;
        end else if (flags_q[`FE_F_OT]) begin
            state_d = ST_HIZ;
        end else if (force_err) begin
            state_d = ST_ERROR;
        end else begin
            state_d = ST_NORMAL;
        end
    end

    // pwm period and duty selection
    logic [CW-1:0] err_period;
    logic [CW-1:0] run_period;
    logic [6:0]    err_pct;
    logic [CW+6:0] pct_prod;
    logic [CW-1:0] err_high;
    logic [CW-1:0] run_high;

    assign err_period = {period_q, 1'b0};

    always_comb begin
        case (1'b1)
            flags_q[`FE_F_UV]:  err_pct = `FE_DUTY_FULL;
            selftest_f:         err_pct = `FE_DUTY_SELFTEST;
            flags_q[`FE_F_ADD]: err_pct = `FE_DUTY_ADDER;
            default:            err_pct = `FE_DUTY_OVERVOLT;
        endcase
    end

    // truncating division keeps the high time at or below the coded share
    assign pct_prod   = (CW+7)'(err_period) * (CW+7)'(err_pct);
    assign err_high   = CW'(pct_prod / (CW+7)'(100));
    // a new period or duty value shows from the next period start, so a long period delays it
    assign run_period = (state_q == ST_ERROR) ? err_period : CW'(period_q);
    assign run_high   = (state_q == ST_ERROR) ? err_high : CW'(duty_q);

    // entering or leaving error mode restarts the period so the code shows at once
    logic pwm_level;
    logic restart_q;

    pwm_core #(.CW(CW)) u_pwm (
        .pclk     (pclk),
        .presetn  (presetn),
        .restart  (restart_q),
        .period   (run_period),
        .high_cnt (run_high),
        .level_q  (pwm_level)
    );

    // polarity bit only counts once the part is locked
    wire pwm_invert = locked & setup_q[`FE_SETUP_BAND];
    // an unlocked part ignores the band bit and goes high
    wire low_band   = locked & setup_q[`FE_SETUP_BAND];

    analog_mode_t am_d;
    always_comb begin
        case (state_q)
            ST_GROUND: am_d = AM_GROUND;
            ST_HIZ:    am_d = AM_TRISTATE;
            ST_ERROR:  am_d = low_band ? AM_LOW_BAND : AM_HIGH_BAND;
            default:   am_d = AM_SIGNAL;
        endcase
    end

    wire pin_oe_d = (state_q != ST_HIZ);
    // analog variant: the pin level stands for the band, 1 for the high band
    logic pin_o_d;
    always_comb begin
        if (state_q == ST_GROUND) begin
            pin_o_d = 1'b0;
        end else if (pwm_var) begin
            pin_o_d = pwm_level ^ pwm_invert;
        end else begin
            pin_o_d = (am_d == AM_HIGH_BAND);
        end
    end

    // apb decode; zero-wait slave: ready is registered from the setup cycle
    // unmapped offsets answer with pslverr and read as zero
    wire setup_ph = psel & ~penable;
    wire wr_en    = psel & penable & pready & pwrite;
    wire hit_setup  = (paddr == `FE_OFS_SETUP);
    wire hit_ctrl   = (paddr == `FE_OFS_CTRL);
    wire hit_period = (paddr == `FE_OFS_PERIOD);
    wire hit_duty   = (paddr == `FE_OFS_DUTY);
    wire hit_status = (paddr == `FE_OFS_STATUS);
    wire hit_any    = hit_setup | hit_ctrl | hit_period | hit_duty | hit_status;

    logic [31:0] rd_mux;
    always_comb begin
        if (hit_setup) begin
            rd_mux = {16'h0000, setup_q};
        end else if (hit_ctrl) begin
            rd_mux = {30'h00000000, ctrl_q};
        end else if (hit_period) begin
            rd_mux = 32'(period_q);
        end else if (hit_duty) begin
            rd_mux = 32'(duty_q);
        end else if (hit_status) begin
            // status: [7:0] flags, [11:8] state, [14:12] analog mode
            rd_mux = {17'h00000, am_d, state_q, flags_q};
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~hit_any;
            prdata  <= (setup_ph & ~pwrite) ? rd_mux : 32'h00000000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_q  <= `FE_SETUP_RST;
            ctrl_q   <= `FE_CTRL_RST;
            period_q <= PW'(`FE_PERIOD_RST);
            duty_q   <= PW'(`FE_DUTY_RST);
        end else if (wr_en) begin
            if (hit_setup) begin
                setup_q <= pwdata[15:0];
            end
            if (hit_ctrl) begin
                ctrl_q <= pwdata[1:0];
            end
            if (hit_period) begin
                period_q <= pwdata[PW-1:0];
            end
            if (hit_duty) begin
                duty_q <= pwdata[PW-1:0];
            end
        end
    end

    // eeprom self-test runs once: one start pulse after reset, result kept till reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ee_started_q  <= 1'b0;
            ee_test_start <= 1'b0;
            ee_fail_q     <= 1'b0;
        end else begin
            ee_started_q  <= 1'b1;
            ee_test_start <= ~ee_started_q;
            if (ee_failed) begin
                ee_fail_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_q   <= 8'h00;
            state_q   <= ST_NORMAL;
            restart_q <= 1'b0;
        end else begin
            flags_q   <= flags_d;
            state_q   <= state_d;
            restart_q <= (state_d != state_q);
        end
    end

    // pin flops add one cycle but keep every top output straight from a register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            analog_mode       <= AM_SIGNAL;
            die_output_pin_o  <= 1'b0;
            die_output_pin_oe <= 1'b0;
        end else begin
            analog_mode       <= am_d;
            die_output_pin_o  <= pin_o_d;
            die_output_pin_oe <= pin_oe_d;
        end
    end
endmodule : sensor_fault_output_encoder

/* src/fault_enc_map.svh */
// register offsets, field positions, reset values and duty codes of the fault encoder
`ifndef FAULT_ENC_MAP_SVH
`define FAULT_ENC_MAP_SVH
`define FE_OFS_SETUP      8'h00
`define FE_OFS_CTRL       8'h04
`define FE_OFS_PERIOD     8'h08
`define FE_OFS_DUTY       8'h0C
`define FE_OFS_STATUS     8'h10
`define FE_SETUP_LOCK     0
`define FE_SETUP_DIAG_OFF 1
`define FE_SETUP_LATCH    2
`define FE_SETUP_OV_OFF   3
`define FE_SETUP_BAND     7
`define FE_CTRL_DIAG_EN   0
`define FE_CTRL_PWM       1
`define FE_SETUP_RST      16'h0000
`define FE_CTRL_RST       2'h0
`define FE_PERIOD_RST     16'h4E20
`define FE_DUTY_RST       16'h2710
`define FE_F_UV           0
`define FE_F_EE           1
`define FE_F_FSM          2
`define FE_F_ROM          3
`define FE_F_ADD          4
`define FE_F_OV           5
`define FE_F_OT           6
`define FE_F_BRK          7
`define FE_DUTY_SELFTEST  7'd95
`define FE_DUTY_ADDER     7'd85
`define FE_DUTY_OVERVOLT  7'd75
`define FE_DUTY_FULL      7'd100
`endif

/* src/fault_enc_pkg.sv */
// types shared by the sensor fault output encoder
package fault_enc_pkg;
    typedef enum logic [3:0] {
        ST_NORMAL = 4'h1,
        ST_ERROR  = 4'h2,
        ST_HIZ    = 4'h4,
        ST_GROUND = 4'h8
    } enc_state_t;
    typedef enum logic [2:0] {
        AM_SIGNAL    = 3'h0,
        AM_HIGH_BAND = 3'h1,
        AM_LOW_BAND  = 3'h2,
        AM_GROUND    = 3'h3,
        AM_TRISTATE  = 3'h4
    } analog_mode_t;
endpackage : fault_enc_pkg

/* src/fault_sync.sv */
// two-stage synchroniser for a group of asynchronous fault levels
module fault_sync #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : fault_sync

/* src/pwm_core.sv */
// period counter producing a pwm level; period and high time are taken at each period start
module pwm_core #(
    parameter int CW = 17
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          restart,
    input  wire logic [CW-1:0] period,
    input  wire logic [CW-1:0] high_cnt,
    output logic               level_q
);
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] per_q;
    logic [CW-1:0] hi_q;
    logic          wrap;

    // a period of 0 or 1 is held at one cycle so the counter never runs away
    assign wrap = restart || (cnt_q + CW'(1) >= per_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= '0;
            per_q   <= '0;
            hi_q    <= '0;
            level_q <= 1'b0;
        end else if (wrap) begin
            cnt_q   <= '0;
            per_q   <= period;
            hi_q    <= high_cnt;
            level_q <= (high_cnt != '0);
        end else begin
            cnt_q   <= cnt_q + CW'(1);
            level_q <= (cnt_q + CW'(1) < hi_q);
        end
    end
endmodule : pwm_core

/* verif/fault_enc_checker.sv */
// port-level assertions for the sensor fault output encoder
module fault_enc_checker
    import fault_enc_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        overtemperature,
    input wire logic        supply_break,
    input wire logic        ee_test_start,
    input wire logic        die_output_pin_o,
    input wire logic        die_output_pin_oe,
    input fault_enc_pkg::analog_mode_t analog_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] starts_q;
    wire  [1:0] starts_d = starts_q + {1'b0, ee_test_start && starts_q != 2'h3};
    wire        mapped   = paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) starts_q <= 2'h0;
        else starts_q <= starts_d;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_follows: assert property (psel && !penable |=> pready) else $error("ready missing");
    a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable)) else $error("ready without setup");
    a_err_map: assert property (pready |-> pslverr == !mapped) else $error("slave error wrong");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("read data outside access");
    a_break_ground: assert property (supply_break [*6] |=>
        analog_mode == AM_GROUND && die_output_pin_oe && !die_output_pin_o) else $error("break not ground");
    a_overtemp_hiz: assert property ((overtemperature && !supply_break) [*6] |=>
        !die_output_pin_oe || analog_mode == AM_GROUND) else $error("overtemp still driving");
    a_hiz_off: assert property (analog_mode == AM_TRISTATE |-> !die_output_pin_oe) else $error("tristate driven");
    a_start_once: assert property (starts_q < 2'h2) else $error("self test started twice");
    c_unmapped: cover property (pready && pslverr);
    c_low_band: cover property (analog_mode == AM_LOW_BAND);
    c_tristate: cover property (analog_mode == AM_TRISTATE);
endmodule : fault_enc_checker

bind sensor_fault_output_encoder fault_enc_checker chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .overtemperature(overtemperature), .supply_break(supply_break),
    .ee_test_start(ee_test_start), .die_output_pin_o(die_output_pin_o),
    .die_output_pin_oe(die_output_pin_oe), .analog_mode(analog_mode)
);

/* verif/output_reader.sv */
// controller model: measures period and high time of the output line
module output_reader (
    input  wire logic pclk,
    input  wire logic pin_o,
    input  wire logic pin_oe,
    output int        high_len,
    output int        period_len
);
    timeunit 1ns;
    timeprecision 1ns;
    int   hc;
    int   pc;
    logic prev;
    // the line has an external pull-up, so a released pin reads high
    wire  level = pin_oe ? pin_o : 1'b1;
    wire  rise  = level && !prev;
    always @(posedge pclk) begin
        prev <= level;
        pc <= rise ? 1 : pc + 1;
        hc <= rise ? 1 : hc + int'(level);
        if (rise) begin
            period_len <= pc;
            high_len <= hc;
        end
    end
endmodule : output_reader

/* verif/sensor_fault_output_encoder_bench.sv */
// self-checking bench for the sensor fault output encoder
`include "fault_enc_map.svh"
module sensor_fault_output_encoder_bench
    import fault_enc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [6:0]   flt = 7'h00; // from bit 0: uv, ov, overtemp, break, rom, fsm, adder
    logic         ee_pass = 1'b1;
    logic         ee_done = 1'b1;
    logic         ee_start;
    logic         pin_o;
    logic         pin_oe;
    analog_mode_t amode;
    logic [31:0]  rd;
    logic         err;
    int           num_errors = 0;
    int           checked = 0;
    int           seed = 37234;
    int           starts = 0;
    int           hi_len;
    int           per_len;

    always #25 pclk = ~pclk;
    always @(posedge pclk) if (ee_start === 1'b1) starts <= starts + 1;

    sensor_fault_output_encoder #(.PW(16)) dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .undervoltage(flt[0]),
        .overvoltage(flt[1]), .overtemperature(flt[2]), .supply_break(flt[3]), .rom_parity_err(flt[4]),
        .fsm_check_err(flt[5]), .adder_overflow(flt[6]), .ee_test_done(ee_done), .ee_test_pass(ee_pass),
        .ee_test_start(ee_start), .die_output_pin_o(pin_o), .die_output_pin_oe(pin_oe), .analog_mode(amode)
    );
    output_reader rd_u (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .high_len(hi_len), .period_len(per_len));

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : conclude
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    // error mode: doubled period, high time is the coded share of it, truncated
    function automatic int err_high(input int per, input int pct);
        return 2 * per * pct / 100;
    endfunction : err_high
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    // one idle cycle after each transfer keeps a following call from re-driving psel in the same step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdc
    task automatic expect_mode(input analog_mode_t m);
        cyc(6);
        check(32'(amode), 32'(m));
    endtask : expect_mode
    task automatic pwm(input logic [6:0] f, input int p, input int h);
        flt <= f;
        cyc(250);
        check(per_len, p);
        check(hi_len, h);
    endtask : pwm
    task automatic do_reset();
        presetn <= 1'b0;
        cyc(10);
        presetn <= 1'b1;
        // the start pulse is counted at the second edge after release; a third lets the count settle
        cyc(3);
    endtask : do_reset

    initial begin
        int i;
        int n;
        logic [31:0] v;
        do_reset();
        check(starts, 1);
        rdc(`FE_OFS_SETUP, 32'(`FE_SETUP_RST));
        rdc(`FE_OFS_CTRL, 32'(`FE_CTRL_RST));
        rdc(`FE_OFS_PERIOD, 32'(`FE_PERIOD_RST));
        rdc(8'h14, 32'h0);
        check(err, 1);
        for (i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(`FE_OFS_DUTY, v);
            rdc(`FE_OFS_DUTY, {16'h0, v[15:0]});
        end
        $display("registers test done");
        wr(`FE_OFS_CTRL, 32'h1);
        wr(`FE_OFS_SETUP, 32'h80);
        flt <= 7'h40;
        expect_mode(AM_HIGH_BAND);
        wr(`FE_OFS_SETUP, 32'h81);
        expect_mode(AM_LOW_BAND);
        wr(`FE_OFS_SETUP, 32'h00);
        flt <= 7'h00;
        expect_mode(AM_SIGNAL);
        for (i = 0; i < 7; i++) if (i != 2 && i != 3) begin
            wr(`FE_OFS_CTRL, 32'h1);
            flt <= 7'h1 << i;
            expect_mode(AM_HIGH_BAND);
            wr(`FE_OFS_CTRL, 32'h0);
            expect_mode(i == 0 ? AM_HIGH_BAND : AM_SIGNAL);
            flt <= 7'h00;
            cyc(6);
        end
        wr(`FE_OFS_CTRL, 32'h1);
        wr(`FE_OFS_SETUP, 32'h8);
        flt <= 7'h02;
        expect_mode(AM_SIGNAL);
        wr(`FE_OFS_SETUP, 32'h2);
        flt <= 7'h01;
        expect_mode(AM_SIGNAL);
        flt <= 7'h04;
        expect_mode(AM_TRISTATE);
        flt <= 7'h0C;
        expect_mode(AM_GROUND);
        check({pin_oe, pin_o}, 2'b10);
        $display("analog test done");
        flt <= 7'h00;
        cyc(6);
        wr(`FE_OFS_SETUP, 32'h4);
        flt <= 7'h10;
        cyc(6);
        flt <= 7'h00;
        expect_mode(AM_HIGH_BAND);
        rdc(`FE_OFS_STATUS, 32'h1208);
        do_reset();
        check(starts, 2);
        $display("latch test done");
        wr(`FE_OFS_PERIOD, 32'd40);
        wr(`FE_OFS_DUTY, 32'd10);
        wr(`FE_OFS_CTRL, 32'h3);
        // a period write waits for the next period start; entering error mode restarts it
        pwm(7'h20, 80, err_high(40, 95));
        pwm(7'h40, 80, err_high(40, 85));
        pwm(7'h02, 80, err_high(40, 75));
        pwm(7'h42, 80, err_high(40, 85));
        flt <= 7'h61;
        cyc(100);
        n = 0;
        repeat (100) begin
            @(posedge pclk);
            n += int'(pin_o === 1'b1 && pin_oe === 1'b1);
        end
        check(n, 100);
        pwm(7'h00, 40, 10);
        $display("pwm test done");
        flt <= 7'h00;
        ee_pass <= 1'b0;
        ee_done <= 1'b0;
        do_reset();
        check(starts, 3);
        wr(`FE_OFS_PERIOD, 32'd40);
        wr(`FE_OFS_CTRL, 32'h3);
        expect_mode(AM_SIGNAL);
        ee_done <= 1'b1;
        pwm(7'h00, 80, err_high(40, 95));
        $display("self test done");
        conclude();
    end

    initial begin
        #1ms;
        num_errors++;
        conclude();
    end
endmodule : sensor_fault_output_encoder_bench
